// File: verilog/vtoc_pkg.sv
/*
  Shared constants and types of the port 1 VT/TU overhead control block.
  Assumes one core clock with synchronous reset; the stream carriers
  below are driven by logic on the same clock.
*/
// How it works
// - While the AIS control bit is set, every transmitted VT/TU byte, V1 to V4 included, is all ones.
// - While the force parity error bit is set, the two BIP-2 bits of V5 go out inverted, every multiframe.
// - While the force far end error bit is set, V5 bit 3 goes out inverted from its normal value.
// - While the remote defect bit is set, V5 bit 8 is sent as one.
// - While the remote failure bit is set, V5 bit 4 is sent as one.
// - The three-bit label goes into V5 bits 5 to 7, label bit 2 landing in V5 bit 7.
// - The low nibble of the channel register fills bits 3 to 6 of the first justification control byte, the high nibble those of the second.
// - The bus select bit takes the dropped tributary from the B-side bus when one and the A-side bus when zero.
// - The seven-bit tributary number with the bus select bit picks the tributary dropped to the port.
// - A tributary number of zero or beyond the range of the bus format selects nothing and the port output carries AIS.
// - In three-STS-1 format numbers run tributary fastest, then group, then STS-1, the last being 84.
// - Clearing the port output enable puts the port data and clock outputs into high impedance.
package vtoc_pkg;

  localparam logic [7:0] VTOC_OFS_TX_OVH_CTRL = 8'h0d;
  localparam logic [7:0] VTOC_OFS_TX_OVH_CHAN = 8'h0e;
  localparam logic [7:0] VTOC_OFS_DROP_SEL = 8'h0f;

  localparam logic [7:0] VTOC_RST_TX_OVH_CTRL = 8'h00;
  localparam logic [7:0] VTOC_RST_TX_OVH_CHAN = 8'h00;
  localparam logic [7:0] VTOC_RST_DROP_SEL = 8'h00;

  // Control and drop select register field positions
  localparam int VTOC_BIT_AIS = 7;
  localparam int VTOC_BIT_PAR_ERR = 6;
  localparam int VTOC_BIT_FEBE_ERR = 5;
  localparam int VTOC_BIT_RDI = 4;
  localparam int VTOC_BIT_RFI = 3;
  localparam int VTOC_LBL_MSB = 2;
  localparam int VTOC_LBL_LSB = 0;
  localparam int VTOC_BIT_BUS_SIDE = 7;
  localparam int VTOC_TRIB_MSB = 6;
  localparam int VTOC_TRIB_LSB = 0;

  // V5 byte layout, bit 1 of the byte is the MSB
  localparam int VTOC_V5_BIP_MSB = 7;
  localparam int VTOC_V5_BIP_LSB = 6;
  localparam int VTOC_V5_FEBE = 5;
  localparam int VTOC_V5_RFI = 4;
  localparam int VTOC_V5_LBL_MSB = 3;
  localparam int VTOC_V5_LBL_LSB = 1;
  localparam int VTOC_V5_RDI = 0;

  // Bits 3 to 6 of a justification control byte
  localparam int VTOC_JC_MSB = 5;
  localparam int VTOC_JC_LSB = 2;

  localparam logic [6:0] VTOC_TRIB_MAX_STS1 = 7'h1c;
  localparam logic [6:0] VTOC_TRIB_MAX_STS3 = 7'h54;
  localparam logic [6:0] VTOC_AIS_SLOT = 7'h01;
  localparam logic [7:0] VTOC_ALL_ONES = 8'hff;

  typedef enum logic [2:0] {
    VTOC_KIND_PTR = 3'h0,
    VTOC_KIND_V5 = 3'h1,
    VTOC_KIND_JC1 = 3'h2,
    VTOC_KIND_JC2 = 3'h3,
    VTOC_KIND_DATA = 3'h4
  } vtoc_kind_t;

  typedef struct packed {
    logic valid;
    logic mf_start;
    vtoc_kind_t kind;
    logic [7:0] data;
  } vtoc_tx_byte_t;

  typedef struct packed {
    logic valid;
    logic mf_start;
    logic [6:0] slot;
    logic [7:0] data;
  } vtoc_drop_byte_t;

endpackage

// File: verilog/vtoc_bip2.sv
/*
  BIP-2 accumulator over the transmitted VT/TU bytes.
  Assumes the stream it watches is the registered block output and that
  V1 to V4 are excluded from parity while V5 opens each multiframe.
*/
`timescale 1ns/1ps
module vtoc_bip2
  import vtoc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire vtoc_tx_byte_t sent,
  output logic [1:0] running
);

  logic [1:0] acc;
  logic [1:0] fold;
  logic counted;

  // Odd byte bits feed the first parity bit, even ones the second
  assign fold = {sent.data[7] ^ sent.data[5] ^ sent.data[3] ^ sent.data[1],
                 sent.data[6] ^ sent.data[4] ^ sent.data[2] ^ sent.data[0]};
  assign counted = sent.valid && (sent.kind != VTOC_KIND_PTR);

  // Includes the byte on the output now, so V5 can use it at once
  assign running = counted && !sent.mf_start ? acc ^ fold : acc;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc <= 2'h0;
    end else if (ce && counted) begin
      if (sent.mf_start) begin
        acc <= fold;
      end else begin
        acc <= acc ^ fold;
      end
    end
  end

endmodule

// File: verilog/vtoc_port1_ctrl.sv
/*
  Port 1 transmit overhead, overhead channel and drop selection control.
  Assumes a same-clock processor port with one-cycle read and write
  strobes, and add/drop byte streams already retimed to core_clk.
*/
`timescale 1ns/1ps
module vtoc_port1_ctrl
  import vtoc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  output logic cpu_rdata_valid,
  input wire logic bus_three_sts1,
  input wire logic port_output_enable,
  input wire vtoc_tx_byte_t tx_in,
  input wire logic tx_febe_value,
  output vtoc_tx_byte_t tx_out,
  input wire vtoc_drop_byte_t drop_a,
  input wire vtoc_drop_byte_t drop_b,
  output logic [7:0] port_drop_data,
  output logic port_drop_valid,
  output logic port_drop_ais,
  output logic drop_bus_side_select,
  output logic [6:0] drop_tributary_number,
  output logic port_data_oe,
  output logic port_clk_oe
);

  function automatic logic trib_in_range(input logic [6:0] num,
                                         input logic three);
    logic [6:0] top;
    top = three ? VTOC_TRIB_MAX_STS3 : VTOC_TRIB_MAX_STS1;
    trib_in_range = (num != 7'h00) && (num <= top);
  endfunction

  // Processor-visible registers
  logic [7:0] tx_ovh_ctrl;
  logic [7:0] tx_ovh_chan;
  logic [7:0] drop_sel;
  // Working copies, refreshed only on a multiframe boundary
  logic [7:0] act_ctrl;
  logic [7:0] act_chan;
  logic [7:0] act_sel;

  logic [1:0] bip_running;
  logic tx_mf_edge;
  logic drop_mf_edge;
  vtoc_drop_byte_t drop_src;
  logic sel_side;
  logic [6:0] sel_num;
  logic sel_ok;
  logic [7:0] next_v5;
  logic [7:0] next_tx_data;
  logic [7:0] ctrl_now;
  logic [7:0] chan_now;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_ovh_ctrl <= VTOC_RST_TX_OVH_CTRL;
      tx_ovh_chan <= VTOC_RST_TX_OVH_CHAN;
      drop_sel <= VTOC_RST_DROP_SEL;
    end else if (ce && cpu_wr) begin
      case (cpu_addr)
        VTOC_OFS_TX_OVH_CTRL: tx_ovh_ctrl <= cpu_wdata;
        VTOC_OFS_TX_OVH_CHAN: tx_ovh_chan <= cpu_wdata;
        VTOC_OFS_DROP_SEL: drop_sel <= cpu_wdata;
        default: ;
      endcase
    end
  end

  // Reads return the written value; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cpu_rdata <= 8'h00;
      cpu_rdata_valid <= 1'b0;
    end else if (ce) begin
      cpu_rdata_valid <= cpu_rd;
      if (cpu_rd) begin
        case (cpu_addr)
          VTOC_OFS_TX_OVH_CTRL: cpu_rdata <= tx_ovh_ctrl;
          VTOC_OFS_TX_OVH_CHAN: cpu_rdata <= tx_ovh_chan;
          VTOC_OFS_DROP_SEL: cpu_rdata <= drop_sel;
          default: cpu_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign tx_mf_edge = tx_in.valid && tx_in.mf_start;

  // Transmit copies switch only where a multiframe begins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      act_ctrl <= VTOC_RST_TX_OVH_CTRL;
      act_chan <= VTOC_RST_TX_OVH_CHAN;
    end else if (ce && tx_mf_edge) begin
      act_ctrl <= tx_ovh_ctrl;
      act_chan <= tx_ovh_chan;
    end
  end

  // The boundary byte itself already uses the new settings
  assign ctrl_now = tx_mf_edge ? tx_ovh_ctrl : act_ctrl;
  assign chan_now = tx_mf_edge ? tx_ovh_chan : act_chan;

  vtoc_bip2 u_bip2 (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .sent(tx_out),
    .running(bip_running)
  );

  always_comb begin
    next_v5 = tx_in.data;
    next_v5[VTOC_V5_BIP_MSB:VTOC_V5_BIP_LSB] =
      ctrl_now[VTOC_BIT_PAR_ERR] ? ~bip_running : bip_running;
    next_v5[VTOC_V5_FEBE] =
      tx_febe_value ^ ctrl_now[VTOC_BIT_FEBE_ERR];
    next_v5[VTOC_V5_RFI] = ctrl_now[VTOC_BIT_RFI];
    next_v5[VTOC_V5_LBL_MSB] = ctrl_now[VTOC_LBL_LSB];
    next_v5[VTOC_V5_LBL_MSB - 1] = ctrl_now[VTOC_LBL_LSB + 1];
    next_v5[VTOC_V5_LBL_LSB] = ctrl_now[VTOC_LBL_MSB];
    next_v5[VTOC_V5_RDI] = ctrl_now[VTOC_BIT_RDI];
  end

  always_comb begin
    next_tx_data = tx_in.data;
    case (tx_in.kind)
      VTOC_KIND_V5: next_tx_data = next_v5;
      VTOC_KIND_JC1:
        next_tx_data[VTOC_JC_MSB:VTOC_JC_LSB] = chan_now[3:0];
      VTOC_KIND_JC2:
        next_tx_data[VTOC_JC_MSB:VTOC_JC_LSB] = chan_now[7:4];
      default: next_tx_data = tx_in.data;
    endcase
    if (ctrl_now[VTOC_BIT_AIS]) begin
      next_tx_data = VTOC_ALL_ONES;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_out <= '0;
    end else if (ce) begin
      tx_out.valid <= tx_in.valid;
      tx_out.mf_start <= tx_in.mf_start;
      tx_out.kind <= tx_in.kind;
      tx_out.data <= next_tx_data;
    end
  end

  // Drop selection also waits for the drop multiframe boundary
  assign drop_mf_edge = (drop_a.valid && drop_a.mf_start) ||
                        (drop_b.valid && drop_b.mf_start);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      act_sel <= VTOC_RST_DROP_SEL;
    end else if (ce && drop_mf_edge) begin
      act_sel <= drop_sel;
    end
  end

  assign sel_side = act_sel[VTOC_BIT_BUS_SIDE];
  assign sel_num = act_sel[VTOC_TRIB_MSB:VTOC_TRIB_LSB];
  assign drop_src = sel_side ? drop_b : drop_a;
  // Numbering is linear, so range is the only check needed
  assign sel_ok = trib_in_range(sel_num, bus_three_sts1);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_drop_data <= 8'h00;
      port_drop_valid <= 1'b0;
      port_drop_ais <= 1'b1;
    end else if (ce) begin
      port_drop_ais <= !sel_ok;
      if (sel_ok) begin
        port_drop_valid <= drop_src.valid &&
                           (drop_src.slot == sel_num);
        port_drop_data <= drop_src.data;
      end else begin
        // AIS keeps the timing of the first tributary slot
        port_drop_valid <= drop_src.valid &&
                           (drop_src.slot == VTOC_AIS_SLOT);
        port_drop_data <= VTOC_ALL_ONES;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      drop_bus_side_select <= 1'b0;
      drop_tributary_number <= 7'h00;
    end else if (ce) begin
      drop_bus_side_select <= sel_side;
      drop_tributary_number <= sel_num;
    end
  end

  // Output enables low at reset: no drive until software allows it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_data_oe <= 1'b0;
      port_clk_oe <= 1'b0;
    end else if (ce) begin
      port_data_oe <= port_output_enable;
      port_clk_oe <= port_output_enable;
    end
  end

endmodule

// File: dv/vtoc_port1_ctrl_props.sv
/*
  Port checker for the port 1 control block, bound to it below.
  Assumes one clock domain and a synchronous reset.
*/
`timescale 1ns/1ps
module vtoc_port1_ctrl_props
  import vtoc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic cpu_rd,
  input wire logic cpu_rdata_valid,
  input wire logic port_output_enable,
  input wire vtoc_drop_byte_t drop_a,
  input wire vtoc_drop_byte_t drop_b,
  input wire logic [7:0] port_drop_data,
  input wire logic port_drop_valid,
  input wire logic port_drop_ais,
  input wire logic drop_bus_side_select,
  input wire logic [6:0] drop_tributary_number,
  input wire logic port_data_oe,
  input wire logic port_clk_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  read_ans_a:
    assert property (ce && cpu_rd |=> cpu_rdata_valid) else $error("no ans");
  rd_cause_a:
    assert property ($past(ce) && cpu_rdata_valid |-> $past(cpu_rd))
      else $error("stray");
  data_oe_a:
    assert property (ce |=> port_data_oe == $past(port_output_enable))
      else $error("data oe");
  clk_oe_a:
    assert property (ce |=> port_clk_oe == $past(port_output_enable))
      else $error("clk oe");
  ais_fill_a:
    assert property (port_drop_valid && port_drop_ais |->
      port_drop_data == VTOC_ALL_ONES) else $error("ais data");
  sel_hold_a:
    assert property (ce && !(drop_a.valid && drop_a.mf_start)
      && !(drop_b.valid && drop_b.mf_start) |-> ##2
      ($stable(drop_tributary_number) && $stable(drop_bus_side_select)))
      else $error("sel moved");
  drop_src_a:
    assert property ($past(ce) && port_drop_valid && !port_drop_ais |->
      port_drop_data == (drop_bus_side_select ? $past(drop_b.data)
      : $past(drop_a.data))) else $error("drop source");
  drop_slot_a:
    assert property ($past(ce) && port_drop_valid && !port_drop_ais |->
      drop_tributary_number == (drop_bus_side_select ?
      $past(drop_b.slot) : $past(drop_a.slot))) else $error("drop slot");
endmodule

bind vtoc_port1_ctrl vtoc_port1_ctrl_props u_props (.core_clk, .sys_rst, .ce,
  .cpu_rd, .cpu_rdata_valid, .port_output_enable, .drop_a, .drop_b,
  .port_drop_data, .port_drop_valid, .port_drop_ais, .drop_bus_side_select,
  .drop_tributary_number, .port_data_oe, .port_clk_oe);

// File: dv/vtoc_bus_model.sv
/*
  Add/drop bus model: MF-byte transmit multiframes, two drop buses.
  Assumes the block samples on the rising edge of core_clk.
*/
`timescale 1ns/1ps
module vtoc_bus_model
  import vtoc_pkg::*;
#(
  parameter int MF = 8
)
(
  input wire logic core_clk,
  input wire logic bus_three_sts1,
  output vtoc_tx_byte_t tx_in,
  output vtoc_drop_byte_t drop_a,
  output vtoc_drop_byte_t drop_b
);
  int pos = 0;
  logic [6:0] slot = 7'h01;
  // Falling edge keeps changes clear of the sampling edge
  always @(negedge core_clk) begin
    tx_in.valid <= 1'b1;
    tx_in.mf_start <= pos == 0;
    tx_in.kind <= pos == 0 ? VTOC_KIND_V5 : pos == 1 ? VTOC_KIND_PTR :
      pos == 2 ? VTOC_KIND_JC1 : pos == 3 ? VTOC_KIND_JC2 : VTOC_KIND_DATA;
    tx_in.data <= {4'(pos), 4'h6};
    pos <= pos == MF - 1 ? 0 : pos + 1;
    drop_a <= '{1'b1, slot == 7'h01, slot, {1'b0, slot}};
    drop_b <= '{1'b1, slot == 7'h01, slot, {1'b1, slot}};
    slot <= slot >= (bus_three_sts1 ? VTOC_TRIB_MAX_STS3 : VTOC_TRIB_MAX_STS1)
      ? 7'h01 : slot + 7'h01;
  end
endmodule

// File: dv/tb_top.sv
/*
  Bench for the port 1 control block with bus model and checker.
  Assumes the model's multiframe length MF; ce is driven by the bench.
*/
`timescale 1ns/1ps
module tb_top
  import vtoc_pkg::*;
;
  localparam int MF = 8;
  logic core_clk = 1'b0, sys_rst = 1'b1, cpu_wr = 1'b0, cpu_rd = 1'b0;
  logic bus_three_sts1 = 1'b1, port_output_enable = 1'b1, ce = 1'b1;
  logic tx_febe_value = 1'b0, dais, cpu_rdata_valid, port_drop_valid;
  logic port_drop_ais, drop_bus_side_select, port_data_oe, port_clk_oe;
  logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, e;
  logic [7:0] cpu_rdata, port_drop_data, v5, ptr, jc1, jc2, drp;
  logic [6:0] drop_tributary_number;
  logic [1:0] acc = 2'b00, bip;
  vtoc_tx_byte_t tx_in, tx_out;
  vtoc_drop_byte_t drop_a, drop_b;
  int num_errors = 0, checks = 0, cyc = 0;
  logic [7:0] ctl[6] = '{8'h40, 8'h25, 8'h80, 8'h12, 8'h0b, 8'h7f};
  logic [7:0] dsel[6] = '{8'h00, 8'h85, 8'h54, 8'hd5, 8'h1c, 8'h9d};
  logic [7:0] dexp[6] = '{8'hff, 8'h85, 8'h54, 8'hff, 8'h1c, 8'hff};
  vtoc_port1_ctrl dut (.core_clk, .sys_rst, .ce, .cpu_addr, .cpu_wdata,
    .cpu_wr, .cpu_rd, .cpu_rdata, .cpu_rdata_valid, .bus_three_sts1,
    .port_output_enable, .tx_in, .tx_febe_value, .tx_out, .drop_a, .drop_b,
    .port_drop_data, .port_drop_valid, .port_drop_ais, .drop_bus_side_select,
    .drop_tributary_number, .port_data_oe, .port_clk_oe);
  vtoc_bus_model #(.MF(MF)) bus (.core_clk, .bus_three_sts1, .tx_in,
    .drop_a, .drop_b);
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // Parity folds every sent byte except V1 to V4
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (port_drop_valid) begin
      drp <= port_drop_data;
      dais <= port_drop_ais;
    end
    if (tx_out.valid && tx_out.kind != VTOC_KIND_PTR)
      acc <= (tx_out.kind == VTOC_KIND_V5 ? 2'b00 : acc) ^ tx_out.data[7:6]
        ^ tx_out.data[5:4] ^ tx_out.data[3:2] ^ tx_out.data[1:0];
    if (tx_out.valid && tx_out.kind == VTOC_KIND_V5)
      bip <= acc;
    if (tx_out.valid && tx_out.kind == VTOC_KIND_V5)
      v5 <= tx_out.data;
    if (tx_out.valid && tx_out.kind == VTOC_KIND_PTR)
      ptr <= tx_out.data;
    if (tx_out.valid && tx_out.kind == VTOC_KIND_JC1)
      jc1 <= tx_out.data;
    if (tx_out.valid && tx_out.kind == VTOC_KIND_JC2)
      jc2 <= tx_out.data;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok) begin
      num_errors++;
      $display("wrong value at %0t ns: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge core_clk);
    cpu_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(negedge core_clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge core_clk);
    // Answer stands only in the cycle after the read edge
    chk(cpu_rdata_valid === 1'b1 && cpu_rdata === x, "read");
    cpu_rd = 1'b0;
  endtask
  task automatic t_regs;
    rd(VTOC_OFS_TX_OVH_CTRL, VTOC_RST_TX_OVH_CTRL);
    rd(VTOC_OFS_TX_OVH_CHAN, VTOC_RST_TX_OVH_CHAN);
    rd(VTOC_OFS_DROP_SEL, VTOC_RST_DROP_SEL);
    wr(8'h10, 8'h5a);
    rd(8'h10, 8'h00);
    wr(VTOC_OFS_TX_OVH_CHAN, 8'ha5);
    rd(VTOC_OFS_TX_OVH_CHAN, 8'ha5);
    $display("registers done");
  endtask
  task automatic t_ovh;
    for (int i = 0; i < 6; i++) begin
      wr(VTOC_OFS_TX_OVH_CTRL, ctl[i]);
      tx_febe_value = i[0];
      repeat (3 * MF) @(negedge core_clk);
      e = ctl[i];
      if (e[7])
        chk({v5, ptr, jc1, jc2} === 32'hffff_ffff, "ais");
      e = {bip ^ {2{e[6]}}, i[0] ^ e[5], e[3], e[0], e[1], e[2], e[4]};
      if (!ctl[i][7])
        chk(v5 === e, "v5");
    end
    chk({jc2[5:2], jc1[5:2]} === 8'ha5, "jc");
    $display("overhead done");
  endtask
  // Waits long enough for a drop multiframe to apply the new selection
  task automatic t_drop;
    for (int i = 0; i < 6; i++) begin
      wr(VTOC_OFS_DROP_SEL, dsel[i]);
      bus_three_sts1 = i < 4;
      repeat (200) @(negedge core_clk);
      chk({dais, drp} === {dexp[i] == 8'hff, dexp[i]}, "d");
      chk({drop_bus_side_select, drop_tributary_number} === dsel[i], "s");
    end
    $display("drop done");
  endtask
  task automatic t_oe;
    port_output_enable = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({port_data_oe, port_clk_oe} === 2'b00, "oe off");
    port_output_enable = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({port_data_oe, port_clk_oe} === 2'b11, "oe on");
    $display("enable done");
  endtask
  // Low ce must drop writes and hold tx_out, port_drop_valid and port_drop_data
  task automatic t_ce;
    vtoc_tx_byte_t held;
    logic [8:0] hdrop;
    @(negedge core_clk);
    ce = 1'b0;
    held = tx_out;
    hdrop = {port_drop_valid, port_drop_data};
    wr(VTOC_OFS_TX_OVH_CHAN, 8'h3c);
    repeat (3) @(negedge core_clk);
    chk(tx_out === held &&
        {port_drop_valid, port_drop_data} === hdrop, "ce hold");
    ce = 1'b1;
    rd(VTOC_OFS_TX_OVH_CHAN, 8'ha5);
    $display("clock enable done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    t_regs();
    t_ovh();
    t_drop();
    t_oe();
    t_ce();
    summarize();
  end
endmodule
